// >>> hdl/dma_pkg.sv
// Constants shared by the descriptor engine end and the root side end.
// Assumes one clock pclk and reset presetn shared by both ends.
// Function
// - Descriptor is four dwords, length then addresses
// - Bit 17 report enable, bit 16 interrupt
// - Second dword is 32-bit endpoint address
// - Host address is third:fourth dword
// - Length counts 32-bit dwords
// - Report enable ORed, writes last done index
// - Interrupt enable ORed, MSI after descriptor
// - Host reaches control through 256-byte memory window
// - Read direction: host memory into endpoint memory
// - Write direction: endpoint memory into host memory
// - Status updated only for reporting descriptors
// - MSI after each descriptor when enabled
// - Header dwords at 0x0, 0x4, 0x8, 0xC
// - Chain starts on fourth header dword write
// - Host polls table status or waits MSI
// - Descriptors start at table plus sixteen
// - Table must not cross 4 KByte
// - Table offset 0xC holds last done index
package dma_pkg;
    // ==========================================================
    // Descriptor layout
    localparam int LEN_W          = 16;
    localparam int CTL_IRQ_BIT    = 16;
    localparam int CTL_REPORT_BIT = 17;
    localparam int DESC_LAST_WORD = 3;
    // ==========================================================
    // Header offsets inside the control window
    localparam logic [7:0] HDR_CTL       = 8'h00;
    localparam logic [7:0] HDR_TBL_HI    = 8'h04;
    localparam logic [7:0] HDR_TBL_LO    = 8'h08;
    localparam logic [7:0] HDR_LAST      = 8'h0C;
    localparam logic [7:0] WRITE_HDR_BASE = 8'h00;
    localparam logic [7:0] READ_HDR_BASE = 8'h10;
    // ==========================================================
    // Offsets inside the descriptor table in host memory
    localparam logic [63:0] TBL_STATUS_OFS = 64'h000000000000000C;
    localparam logic [63:0] TBL_DESC_OFS   = 64'h0000000000000010;
    // ==========================================================
    // Root side APB registers
    localparam logic [7:0] A_CMD        = 8'h00;
    localparam logic [7:0] A_CMD_DATA   = 8'h04;
    localparam logic [7:0] A_CMD_RDATA  = 8'h08;
    localparam logic [7:0] A_BUSY       = 8'h0C;
    localparam logic [7:0] A_IRQ_STATUS = 8'h10;
    localparam logic [7:0] A_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] A_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] A_MEM_ADDR   = 8'h20;
    localparam logic [7:0] A_MEM_DATA   = 8'h24;
    localparam int         CMD_READ_BIT = 8;
    localparam int         IRQ_MSI_BIT  = 0;
    localparam int         IRQ_HDR_BIT  = 1;
    localparam logic [31:0] REG_RESET   = 32'h00000000;
    // ==========================================================
    // Engine states
    typedef enum logic [5:0] {
        S_IDLE   = 6'h01,
        S_FETCH  = 6'h02,
        S_RD     = 6'h04,
        S_WR     = 6'h08,
        S_REPORT = 6'h10,
        S_MSI    = 6'h20
    } eng_state_t;
endpackage

// >>> hdl/dma_link_if.sv
// Link between the root side and the descriptor engine end.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface dma_link_if;
    // Header register access, root to engine
    logic        hdr_valid;
    logic        hdr_write;
    logic [7:0]  hdr_addr;
    logic [31:0] hdr_wdata;
    logic        hdr_ack;
    logic [31:0] hdr_rdata;
    // Host memory access, engine to root
    logic        mem_req;
    logic        mem_write;
    logic [63:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    // Message interrupt pulse
    logic        msi;
    modport device (input hdr_valid, hdr_write, hdr_addr, hdr_wdata, mem_ack, mem_rdata,
                    output hdr_ack, hdr_rdata, mem_req, mem_write, mem_addr, mem_wdata, msi);
    modport root (output hdr_valid, hdr_write, hdr_addr, hdr_wdata, mem_ack, mem_rdata,
                  input hdr_ack, hdr_rdata, mem_req, mem_write, mem_addr, mem_wdata, msi);
endinterface
`default_nettype wire

// >>> hdl/dma_engine_end.sv
// Chaining descriptor engine with its own endpoint memory.
// Assumes the root side answers every host memory request.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dma_engine_end #(
    parameter int EP_WORDS = 4096
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link to the root side
    dma_link_if.device       link,
    // User side status
    output logic             busy,
    output logic             active_dir,
    output logic [15:0]      last_done_index,
    // Endpoint memory peek port
    input  wire logic [31:0] ep_peek_addr,
    output logic [31:0]      ep_peek_data
);
    localparam int EPA = $clog2(EP_WORDS);

    // ==========================================================
    // Header registers, one set per direction
    dma_pkg::eng_state_t state;
    logic                dir;
    logic [1:0]          take;
    wire  logic          hdr_take = link.hdr_valid & ~link.hdr_ack;
    wire  logic          hdr_wr   = hdr_take & link.hdr_write;

    for (genvar g = 0; g < 2; g++) begin : g_dir
        localparam logic [7:0] BASE = (g == 0) ? dma_pkg::WRITE_HDR_BASE
                                               : dma_pkg::READ_HDR_BASE;
        logic [31:0] ctl;
        logic [31:0] tbl_hi;
        logic [31:0] tbl_lo;
        logic [31:0] last;
        logic        pend;
        wire  logic  hit = hdr_wr & (link.hdr_addr[7:4] == BASE[7:4]);
        wire  logic  start = hit & (link.hdr_addr[3:0] == dma_pkg::HDR_LAST[3:0]);

        // Header dwords; the fourth one arms the chain
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl    <= dma_pkg::REG_RESET;
                tbl_hi <= dma_pkg::REG_RESET;
                tbl_lo <= dma_pkg::REG_RESET;
                last   <= dma_pkg::REG_RESET;
                pend   <= 1'b0;
            end else begin
                if (hit && link.hdr_addr[3:0] == dma_pkg::HDR_CTL[3:0]) begin
                    ctl <= link.hdr_wdata;
                end else if (hit && link.hdr_addr[3:0] == dma_pkg::HDR_TBL_HI[3:0]) begin
                    tbl_hi <= link.hdr_wdata;
                end else if (hit && link.hdr_addr[3:0] == dma_pkg::HDR_TBL_LO[3:0]) begin
                    tbl_lo <= link.hdr_wdata;
                end else if (start) begin
                    last <= link.hdr_wdata;
                end
                // A new start wins over the take in the same cycle
                pend <= start | (pend & ~take[g]);
            end
        end
    end

    // ==========================================================
    // Header read back; unmapped offsets read zero
    logic [31:0] hdr_mux;
    always_comb begin
        hdr_mux = 32'h00000000;
        if (link.hdr_addr[7:4] == dma_pkg::READ_HDR_BASE[7:4] ||
            link.hdr_addr[7:4] == dma_pkg::WRITE_HDR_BASE[7:4]) begin
            if (link.hdr_addr[3:0] == dma_pkg::HDR_CTL[3:0]) begin
                hdr_mux = link.hdr_addr[4] ? g_dir[1].ctl : g_dir[0].ctl;
            end else if (link.hdr_addr[3:0] == dma_pkg::HDR_TBL_HI[3:0]) begin
                hdr_mux = link.hdr_addr[4] ? g_dir[1].tbl_hi : g_dir[0].tbl_hi;
            end else if (link.hdr_addr[3:0] == dma_pkg::HDR_TBL_LO[3:0]) begin
                hdr_mux = link.hdr_addr[4] ? g_dir[1].tbl_lo : g_dir[0].tbl_lo;
            end else if (link.hdr_addr[3:0] == dma_pkg::HDR_LAST[3:0]) begin
                hdr_mux = link.hdr_addr[4] ? g_dir[1].last : g_dir[0].last;
            end
        end
    end

    // One-cycle answer to each header access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.hdr_ack   <= 1'b0;
            link.hdr_rdata <= 32'h00000000;
        end else begin
            link.hdr_ack <= hdr_take;
            if (hdr_take && !link.hdr_write) begin
                link.hdr_rdata <= hdr_mux;
            end
        end
    end

    // ==========================================================
    // Selection of the active header and descriptor fields
    logic [15:0] idx;
    logic [1:0]  k;
    logic [15:0] pos;
    logic [31:0] d_ctl;
    logic [31:0] d_ep;
    logic [31:0] d_hi;
    logic [31:0] d_lo;
    logic [31:0] dword;

    wire logic [31:0] cur_ctl  = dir ? g_dir[1].ctl : g_dir[0].ctl;
    wire logic [63:0] tbl      = dir ? {g_dir[1].tbl_hi, g_dir[1].tbl_lo}
                                     : {g_dir[0].tbl_hi, g_dir[0].tbl_lo};
    wire logic [15:0] last_idx = dir ? g_dir[1].last[15:0] : g_dir[0].last[15:0];
    wire logic [15:0] len      = d_ctl[dma_pkg::LEN_W-1:0];
    wire logic [15:0] len_m1   = len - 16'h0001;
    wire logic        last_word = (pos == len_m1);
    wire logic        report_en = d_ctl[dma_pkg::CTL_REPORT_BIT]
                                | cur_ctl[dma_pkg::CTL_REPORT_BIT];
    wire logic        irq_en    = d_ctl[dma_pkg::CTL_IRQ_BIT]
                                | cur_ctl[dma_pkg::CTL_IRQ_BIT];

    // Descriptor n sits at table + 16 + 16 * n, dword k inside it
    wire logic [63:0] desc_addr = tbl + dma_pkg::TBL_DESC_OFS
                                + {44'h0, idx, 4'h0} + {60'h0, k, 2'b00};
    wire logic [63:0] status_addr = tbl + dma_pkg::TBL_STATUS_OFS;
    wire logic [63:0] host_addr = {d_hi, d_lo} + {46'h0, pos, 2'b00};
    wire logic [31:0] ep_sum    = {2'b00, d_ep[31:2]} + {16'h0000, pos};
    wire logic [EPA-1:0] ep_idx = ep_sum[EPA-1:0];

    assign take = {(state == dma_pkg::S_IDLE) & ~g_dir[0].pend & g_dir[1].pend,
                   (state == dma_pkg::S_IDLE) & g_dir[0].pend};

    // ==========================================================
    // Host memory requests come straight from the state
    wire logic st_fetch  = (state == dma_pkg::S_FETCH);
    wire logic st_report = (state == dma_pkg::S_REPORT);
    wire logic host_rd   = (state == dma_pkg::S_RD) & dir;
    wire logic host_wr   = (state == dma_pkg::S_WR) & ~dir;
    wire logic rep_wr    = st_report & report_en;

    assign link.mem_req   = st_fetch | host_rd | host_wr | rep_wr;
    assign link.mem_write = host_wr | rep_wr;
    assign link.mem_addr  = st_fetch ? desc_addr : (st_report ? status_addr : host_addr);
    assign link.mem_wdata = st_report ? {16'h0000, idx} : dword;
    assign busy           = (state != dma_pkg::S_IDLE);

    // ==========================================================
    // Endpoint memory; no reset, contents are undefined at start
    logic [31:0] ep_mem [EP_WORDS];
    always_ff @(posedge pclk) begin
        if (state == dma_pkg::S_WR && dir) begin
            ep_mem[ep_idx] <= dword;
        end
        ep_peek_data <= ep_mem[ep_peek_addr[EPA+1:2]];
    end

    // ==========================================================
    // Chain walker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= dma_pkg::S_IDLE;
            dir             <= 1'b0;
            idx             <= 16'h0000;
            k               <= 2'b00;
            pos             <= 16'h0000;
            d_ctl           <= dma_pkg::REG_RESET;
            d_ep            <= dma_pkg::REG_RESET;
            d_hi            <= dma_pkg::REG_RESET;
            d_lo            <= dma_pkg::REG_RESET;
            dword           <= 32'h00000000;
            link.msi        <= 1'b0;
            last_done_index <= 16'h0000;
        end else begin
            link.msi <= 1'b0;
            case (state)
                dma_pkg::S_IDLE: begin
                    // Write direction first when both are armed
                    if (take != 2'b00) begin
                        dir   <= take[1];
                        idx   <= 16'h0000;
                        k     <= 2'b00;
                        state <= dma_pkg::S_FETCH;
                    end
                end
                dma_pkg::S_FETCH: begin
                    if (link.mem_ack) begin
                        k <= k + 2'b01;
                        if (k == 2'd0) d_ctl <= link.mem_rdata;
                        if (k == 2'd1) d_ep <= link.mem_rdata;
                        if (k == 2'd2) d_hi <= link.mem_rdata;
                        if (k == 2'(dma_pkg::DESC_LAST_WORD)) begin
                            d_lo  <= link.mem_rdata;
                            pos   <= 16'h0000;
                            state <= (len == 16'h0000) ? dma_pkg::S_REPORT
                                                       : dma_pkg::S_RD;
                        end
                    end
                end
                dma_pkg::S_RD: begin
                    if (!dir) begin
                        dword <= ep_mem[ep_idx];
                        state <= dma_pkg::S_WR;
                    end else if (link.mem_ack) begin
                        dword <= link.mem_rdata;
                        state <= dma_pkg::S_WR;
                    end
                end
                dma_pkg::S_WR: begin
                    if (dir || link.mem_ack) begin
                        pos   <= pos + 16'h0001;
                        state <= last_word ? dma_pkg::S_REPORT : dma_pkg::S_RD;
                    end
                end
                dma_pkg::S_REPORT: begin
                    // Skipped in one cycle when reporting is off
                    if (!report_en || link.mem_ack) begin
                        state <= dma_pkg::S_MSI;
                    end
                end
                dma_pkg::S_MSI: begin
                    link.msi        <= irq_en;
                    last_done_index <= idx;
                    k               <= 2'b00;
                    if (idx == last_idx) begin
                        state <= dma_pkg::S_IDLE;
                    end else begin
                        idx   <= idx + 16'h0001;
                        state <= dma_pkg::S_FETCH;
                    end
                end
                default: state <= dma_pkg::S_IDLE;
            endcase
        end
    end

    assign active_dir = dir;
endmodule
`default_nettype wire

// >>> hdl/root_port_end.sv
// Root side: host memory, header command port and MSI capture.
// Assumes an APB master for software; the engine sits on the link.
`timescale 1ns/1ps
`default_nettype none
module root_port_end #(
    parameter int HOST_WORDS = 65536
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Link to the engine
    dma_link_if.root         link
);
    localparam int HA = $clog2(HOST_WORDS);

    // ==========================================================
    // Decode
    wire logic setup  = psel & ~penable;
    wire logic apb_wr = psel & penable & pwrite;
    wire logic mapped = (paddr == dma_pkg::A_CMD) || (paddr == dma_pkg::A_CMD_DATA)
                     || (paddr == dma_pkg::A_CMD_RDATA) || (paddr == dma_pkg::A_BUSY)
                     || (paddr == dma_pkg::A_IRQ_STATUS) || (paddr == dma_pkg::A_IRQ_CLEAR)
                     || (paddr == dma_pkg::A_IRQ_ENABLE) || (paddr == dma_pkg::A_MEM_ADDR)
                     || (paddr == dma_pkg::A_MEM_DATA);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    logic [31:0] cmd_rdata;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic [31:0] mem_ptr;
    logic [31:0] host_mem [HOST_WORDS];
    wire  logic  idle_cmd = ~link.hdr_valid;
    wire  logic  cmd_rd = apb_wr & (paddr == dma_pkg::A_CMD) & pwdata[dma_pkg::CMD_READ_BIT];
    wire  logic  cmd_wr = apb_wr & (paddr == dma_pkg::A_CMD_DATA);
    wire  logic  mem_take = link.mem_req & ~link.mem_ack;
    wire  logic [HA-1:0] link_idx = link.mem_addr[HA+1:2];
    wire  logic [HA-1:0] sw_idx = mem_ptr[HA-1:0];

    assign irq = |(irq_status & irq_enable);

    // ==========================================================
    // Read data captured in the setup cycle, shown in the access
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (paddr == dma_pkg::A_CMD) begin
            rd_mux = {24'h000000, link.hdr_addr};
        end else if (paddr == dma_pkg::A_CMD_RDATA) begin
            rd_mux = cmd_rdata;
        end else if (paddr == dma_pkg::A_BUSY) begin
            rd_mux = {31'h00000000, link.hdr_valid};
        end else if (paddr == dma_pkg::A_IRQ_STATUS) begin
            rd_mux = {30'h00000000, irq_status};
        end else if (paddr == dma_pkg::A_IRQ_ENABLE) begin
            rd_mux = {30'h00000000, irq_enable};
        end else if (paddr == dma_pkg::A_MEM_ADDR) begin
            rd_mux = mem_ptr;
        end else if (paddr == dma_pkg::A_MEM_DATA) begin
            rd_mux = host_mem[sw_idx];
        end
    end

    // ==========================================================
    // Registers and header command; commands while busy are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata         <= dma_pkg::REG_RESET;
            cmd_rdata      <= dma_pkg::REG_RESET;
            irq_status     <= 2'b00;
            irq_enable     <= 2'b00;
            mem_ptr        <= dma_pkg::REG_RESET;
            link.hdr_valid <= 1'b0;
            link.hdr_write <= 1'b0;
            link.hdr_addr  <= 8'h00;
            link.hdr_wdata <= dma_pkg::REG_RESET;
        end else begin
            if (setup) prdata <= rd_mux;
            if (apb_wr && paddr == dma_pkg::A_CMD && idle_cmd) begin
                link.hdr_addr <= pwdata[7:0];
            end
            if (apb_wr && paddr == dma_pkg::A_IRQ_ENABLE) irq_enable <= pwdata[1:0];
            if (apb_wr && paddr == dma_pkg::A_MEM_ADDR) mem_ptr <= pwdata;
            if (idle_cmd && (cmd_rd || cmd_wr)) begin
                link.hdr_valid <= 1'b1;
                link.hdr_write <= cmd_wr;
                if (cmd_wr) link.hdr_wdata <= pwdata;
            end else if (link.hdr_ack) begin
                link.hdr_valid <= 1'b0;
                if (!link.hdr_write) cmd_rdata <= link.hdr_rdata;
            end
            // Hardware set wins over the software clear
            irq_status <= (irq_status & ~((apb_wr && paddr == dma_pkg::A_IRQ_CLEAR)
                                          ? pwdata[1:0] : 2'b00))
                        | {link.hdr_ack, link.msi};
        end
    end

    // ==========================================================
    // Host memory; the engine's write wins over software's
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.mem_ack   <= 1'b0;
            link.mem_rdata <= 32'h00000000;
        end else begin
            link.mem_ack <= mem_take;
            if (mem_take) link.mem_rdata <= host_mem[link_idx];
        end
    end

    always_ff @(posedge pclk) begin
        if (apb_wr && paddr == dma_pkg::A_MEM_DATA) host_mem[sw_idx] <= pwdata;
        if (mem_take && link.mem_write) host_mem[link_idx] <= link.mem_wdata;
    end
endmodule
`default_nettype wire

// >>> tb/dma_link_monitor.sv
// Checker on the link that joins the root side and the engine.
// Assumes one clock; the bench top instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module dma_link_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link signals
    input wire logic        hdr_valid,
    input wire logic        hdr_write,
    input wire logic [7:0]  hdr_addr,
    input wire logic        hdr_ack,
    input wire logic        mem_req,
    input wire logic        mem_write,
    input wire logic [63:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        msi
);
    // ==========================================================
    // Handshake and chain start checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Last index dword taken by the engine, then a descriptor fetch
    sequence last_taken; hdr_ack && hdr_write && hdr_addr[3:0] == 4'hC; endsequence
    sequence fetch_seen; mem_req && !mem_write; endsequence
    a_chain_start: assert property (last_taken |-> ##[1:16] fetch_seen)
        else $error("no descriptor fetch after last index write");
    a_hdr_ack_pulse: assert property (hdr_ack |=> !hdr_ack)
        else $error("header ack longer than one cycle");
    a_hdr_ack_cause: assert property (hdr_ack |-> $past(hdr_valid))
        else $error("header ack without request");
    a_mem_req_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_write)) else $error("memory request dropped");
    a_mem_ack_next: assert property (mem_req && !mem_ack |=> mem_ack)
        else $error("memory request not answered next cycle");
    a_ack_has_req: assert property (mem_ack |-> mem_req)
        else $error("memory ack without request");
    a_word_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
        else $error("host address not dword aligned");
    a_msi_pulse: assert property (msi |=> !msi)
        else $error("interrupt pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/chaining_dma_descriptor_engine_tb_top.sv
// Bench top: both ends joined by the link, APB stimulus, memory model.
// Assumes the package, link interface and both ends compile first.
`timescale 1ns/1ps
`default_nettype none
module chaining_dma_descriptor_engine_tb_top;
    // ==========================================================
    // Signals, ends and checker
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, ep_peek_addr = 32'h0, prdata, ep_peek_data, rd, hm[int], em[int];
    logic        pready, pslverr, irq, busy, active_dir, er;
    logic [15:0] last_done_index;
    logic [31:0] sq[$];
    logic [63:0] stat_addr = 64'h0;
    int          errors = 0, checks = 0, msi_n = 0, wq[$];
    dma_link_if link ();
    root_port_end root_port_end_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    dma_engine_end dma_engine_end_i (.pclk(pclk), .presetn(presetn), .link(link), .busy(busy),
        .active_dir(active_dir), .last_done_index(last_done_index),
        .ep_peek_addr(ep_peek_addr), .ep_peek_data(ep_peek_data));
    dma_link_monitor dma_link_monitor_i (.pclk(pclk), .presetn(presetn),
        .hdr_valid(link.hdr_valid), .hdr_write(link.hdr_write), .hdr_addr(link.hdr_addr),
        .hdr_ack(link.hdr_ack), .mem_req(link.mem_req), .mem_write(link.mem_write),
        .mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .msi(link.msi));
    // 250 MHz clock
    initial forever #2 pclk = ~pclk;
    // Status writes and interrupt pulses, seen where the ack lands
    always @(posedge pclk) begin
        if (link.mem_req && link.mem_ack && link.mem_write && link.mem_addr == stat_addr)
            sq.push_back(link.mem_wdata);
        if (link.msi === 1'b1) msi_n++;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 64) begin errors++; complete_run(); end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Header write, or read when r is set, through the command port; then polls busy until it clears
    task automatic hdr(input logic [7:0] o, input logic [31:0] v, input bit r = 0);
        apb(1, dma_pkg::A_CMD, {23'h000000, r, o});
        if (!r) apb(1, dma_pkg::A_CMD_DATA, v);
        repeat (64) begin apb(0, dma_pkg::A_BUSY, 32'h0); if (rd[0] === 1'b0) return; end
        errors++; complete_run();
    endtask
    task automatic hw(input int i, input logic [31:0] v);
        apb(1, dma_pkg::A_MEM_ADDR, 32'(i)); apb(1, dma_pkg::A_MEM_DATA, v); hm[i] = v;
    endtask
    task automatic hr(input int i);
        apb(1, dma_pkg::A_MEM_ADDR, 32'(i)); apb(0, dma_pkg::A_MEM_DATA, 32'h0);
    endtask
    task automatic peek(input int a);
        ep_peek_addr <= 32'(a); @(posedge pclk); @(posedge pclk); rd = ep_peek_data;
    endtask
    // Descriptor into host memory; the model moves words the same way
    task automatic desc(input int t, k, ctl, ep, ha, input bit r);
        int j;
        hw(t/4+4+4*k, 32'(ctl)); hw(t/4+5+4*k, 32'(ep)); hw(t/4+6+4*k, 32'h0); hw(t/4+7+4*k, 32'(ha));
        for (j = 0; j < (ctl & 'hFFFF); j++)
            if (r) em[ep/4+j] = hm[ha/4+j];
            else begin hm[ha/4+j] = em[ep/4+j]; wq.push_back(ha/4+j); end
    endtask
    // Header with the last index written last, then wait for the chain
    task automatic run(input logic [7:0] hb, input int t, ctl, last, nmsi);
        int n;
        stat_addr = 64'(t + 12); sq.delete(); msi_n = 0; hw(t/4+3, 32'hFFFF);
        hdr(hb + dma_pkg::HDR_CTL, 32'(ctl)); hdr(hb + dma_pkg::HDR_TBL_HI, 32'h0);
        hdr(hb + dma_pkg::HDR_TBL_LO, 32'(t)); hdr(hb + dma_pkg::HDR_LAST, 32'(last));
        for (n = 0; n < 3000 && (busy !== 1'b0 || msi_n < nmsi); n++) @(posedge pclk);
        chk(32'(n < 3000), 1, "chain done");
        if (n == 3000) complete_run();
        chk(32'(msi_n), 32'(nmsi), "msi count");
        chk({16'h0, last_done_index}, 32'(last), "last done");
        hr(t/4+3); chk(rd, 32'(last), "status word");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        int k;
        void'($urandom(32'h483e));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 7; k++) hw('h800 + k, $urandom());
        // Read chain: report on first and last, interrupt on last, empty middle
        desc('h900, 0, 'h20003, 'h10, 'h2000, 1); desc('h900, 1, 0, 'h40, 'h2010, 1);
        desc('h900, 2, 'h30004, 'h80, 'h200C, 1);
        run(dma_pkg::READ_HDR_BASE, 'h900, 3, 2, 1);
        chk(32'(sq.size()), 2, "status writes");
        chk(sq[0], 0, "first status");
        foreach (em[i]) begin peek(i*4); chk(rd, em[i], "ep word"); end
        chk(32'(active_dir), 1, "read dir");
        // Header read back over the command port
        hdr(dma_pkg::READ_HDR_BASE + dma_pkg::HDR_LAST, 32'h0, 1);
        apb(0, dma_pkg::A_CMD_RDATA, 0); chk(rd, 2, "header read");
        // Interrupt status, mask, clear; unmapped access
        apb(0, dma_pkg::A_IRQ_STATUS, 0); chk(32'(rd[1:0]), 3, "irq status");
        chk(32'(irq), 0, "masked irq");
        apb(1, dma_pkg::A_IRQ_ENABLE, 1); chk(32'(irq), 1, "irq");
        apb(1, dma_pkg::A_IRQ_CLEAR, 3); chk(32'(irq), 0, "cleared irq");
        apb(0, 8'h40, 0); chk(32'(er), 1, "unmapped");
        // Write chain: enables only in the header, ORed into each descriptor
        desc('hA00, 0, 4, 'h80, 'h3000, 0); desc('hA00, 1, 3, 'h10, 'h3010, 0);
        run(dma_pkg::WRITE_HDR_BASE, 'hA00, 'h30002, 1, 2);
        chk(32'(sq.size()), 2, "status writes");
        chk(32'(active_dir), 0, "write dir");
        foreach (wq[i]) begin hr(wq[i]); chk(rd, hm[wq[i]], "host word"); end
        complete_run();
    end
endmodule
`default_nettype wire
